// ==== gpcfg_bank.sv ====
// pin configuration register bank behind the index/data configuration port
`timescale 1ns/100ps

module gpcfg_bank (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic main_por_req,
    input wire logic hard_rst_req,
    input wire logic cfg_mode,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_port_sel,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [7:0] grp4_out_val,
    input wire logic [7:0] grp4_pad_i,
    output logic [7:0] grp4_pad_o,
    output logic [7:0] grp4_pad_oe,
    output logic [7:0] grp4_in_val,
    input wire logic [7:0] grp5_out_val,
    input wire logic [7:0] grp5_pad_i,
    output logic [7:0] grp5_pad_o,
    output logic [7:0] grp5_pad_oe,
    output logic [7:0] grp5_in_val,
    input wire logic sys_mgmt_irq_req,
    input wire logic pin_twelve_gp_val,
    input wire logic pin_twelve_gp_dir,
    input wire logic pin_twelve_gp_pol,
    input wire logic pin_twelve_pad_i,
    output logic pin_twelve_pad_o,
    output logic pin_twelve_pad_oe,
    output logic pin_twelve_in_val,
    output gpcfg_pkg::gpcfg_route_type route
);

    // ****************************************
    // state
    // ****************************************
    gpcfg_pkg::gpcfg_state_type state_ff;
    gpcfg_pkg::gpcfg_state_type nxt_state;

    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic idx_rd;
    logic [7:0] rd_val;
    logic [gpcfg_pkg::SYNC_W-1:0] pad_raw;
    logic [7:0] pol4_in;
    logic [7:0] pol5_in;
    logic p12_level;

    // ****************************************
    // port decode
    // ****************************************
    // accesses outside configuration state are dropped; the host is expected not to make them
    always_comb begin
        idx_wr = io_wr && cfg_mode && (io_port_sel == gpcfg_pkg::PORT_INDEX);
        data_wr = io_wr && cfg_mode && (io_port_sel == gpcfg_pkg::PORT_DATA);
        idx_rd = io_rd && cfg_mode && (io_port_sel == gpcfg_pkg::PORT_INDEX);
        data_rd = io_rd && cfg_mode && (io_port_sel == gpcfg_pkg::PORT_DATA);
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_val = gpcfg_pkg::RST_ZERO;
        unique case (state_ff.index)
            gpcfg_pkg::IDX_DIR4: begin
                rd_val = state_ff.regs.dir4;
            end
            gpcfg_pkg::IDX_POL4: begin
                rd_val = state_ff.regs.pol4;
            end
            gpcfg_pkg::IDX_DRV1: begin
                rd_val = state_ff.regs.drv1 & gpcfg_pkg::MASK_DRV1;
            end
            gpcfg_pkg::IDX_TEST5: begin
                rd_val = state_ff.regs.test5;
            end
            gpcfg_pkg::IDX_DRV2: begin
                rd_val = state_ff.regs.drv2 & gpcfg_pkg::MASK_DRV2;
            end
            gpcfg_pkg::IDX_DRV5: begin
                rd_val = state_ff.regs.drv5;
            end
            gpcfg_pkg::IDX_DIR5: begin
                rd_val = state_ff.regs.dir5;
            end
            gpcfg_pkg::IDX_POL5: begin
                rd_val = state_ff.regs.pol5;
            end
            gpcfg_pkg::IDX_ALT1: begin
                rd_val = state_ff.regs.alt1 & gpcfg_pkg::MASK_ALT1;
            end
            gpcfg_pkg::IDX_ALT2: begin
                rd_val = state_ff.regs.alt2 & gpcfg_pkg::MASK_ALT2;
            end
            gpcfg_pkg::IDX_ALT3: begin
                rd_val = state_ff.regs.alt3;
            end
            gpcfg_pkg::IDX_ALT5: begin
                rd_val = state_ff.regs.alt5;
            end
            // 0x3B-0x3F, 0x47 and every index outside this bank read zero
            default: begin
                rd_val = gpcfg_pkg::RST_ZERO;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        pad_raw = {pin_twelve_pad_i, grp5_pad_i, grp4_pad_i};
        pol4_in = state_ff.regs.pol4;
        pol5_in = state_ff.regs.pol5;
        p12_level = 1'b0;

        if (clk_en) begin
            // register port
            if (idx_wr) begin
                nxt_state.index = io_wdata;
            end
            if (data_wr) begin
                unique case (state_ff.index)
                    gpcfg_pkg::IDX_DIR4: begin
                        nxt_state.regs.dir4 = io_wdata;
                    end
                    gpcfg_pkg::IDX_POL4: begin
                        nxt_state.regs.pol4 = io_wdata;
                    end
                    gpcfg_pkg::IDX_DRV1: begin
                        nxt_state.regs.drv1 = io_wdata & gpcfg_pkg::MASK_DRV1;
                    end
                    gpcfg_pkg::IDX_TEST5: begin
                        // stored but wired to nothing: test modes are not built into this bank
                        nxt_state.regs.test5 = io_wdata;
                    end
                    gpcfg_pkg::IDX_DRV2: begin
                        nxt_state.regs.drv2 = io_wdata & gpcfg_pkg::MASK_DRV2;
                    end
                    gpcfg_pkg::IDX_DRV5: begin
                        nxt_state.regs.drv5 = io_wdata;
                    end
                    gpcfg_pkg::IDX_DIR5: begin
                        nxt_state.regs.dir5 = io_wdata;
                    end
                    gpcfg_pkg::IDX_POL5: begin
                        nxt_state.regs.pol5 = io_wdata;
                    end
                    gpcfg_pkg::IDX_ALT1: begin
                        nxt_state.regs.alt1 = io_wdata & gpcfg_pkg::MASK_ALT1;
                    end
                    gpcfg_pkg::IDX_ALT2: begin
                        nxt_state.regs.alt2 = io_wdata & gpcfg_pkg::MASK_ALT2;
                    end
                    gpcfg_pkg::IDX_ALT3: begin
                        nxt_state.regs.alt3 = io_wdata;
                    end
                    gpcfg_pkg::IDX_ALT5: begin
                        nxt_state.regs.alt5 = io_wdata;
                    end
                    default: begin
                        nxt_state.regs = state_ff.regs;
                    end
                endcase
            end
            if (data_rd) begin
                nxt_state.rdata = rd_val;
            end else if (idx_rd) begin
                nxt_state.rdata = state_ff.index;
            end

            // main-power and hard resets act after any write in the same cycle
            if (main_por_req) begin
                nxt_state.regs.test5 = gpcfg_pkg::RST_ZERO;
                nxt_state.index = gpcfg_pkg::RST_ZERO;
            end
            if (main_por_req || hard_rst_req) begin
                nxt_state.regs.alt2[7:4] = gpcfg_pkg::RST_ALT2_HI;
            end

            // pad inputs: three stages, accept a change once stages two and three agree
            nxt_state.sync1 = pad_raw;
            nxt_state.sync2 = state_ff.sync1;
            nxt_state.sync3 = state_ff.sync2;
            for (int i = 0; i < gpcfg_pkg::SYNC_W; i++) begin
                if (state_ff.sync2[i] == state_ff.sync3[i]) begin
                    nxt_state.filt[i] = state_ff.sync3[i];
                end
            end

            // group 4 is always push-pull
            nxt_state.grp4.o = grp4_out_val ^ pol4_in;
            nxt_state.grp4.oe = state_ff.regs.dir4;
            nxt_state.grp4.in_val = state_ff.filt[7:0] ^ pol4_in;

            // an open-drain pin only ever pulls low
            nxt_state.grp5.o = grp5_out_val ^ pol5_in;
            for (int i = 0; i < 8; i++) begin
                nxt_state.grp5.oe[i] = state_ff.regs.dir5[i]
                    && (!state_ff.regs.drv5[i] || !(grp5_out_val[i] ^ pol5_in[i]));
            end
            nxt_state.grp5.in_val = state_ff.filt[15:8] ^ pol5_in;

            // pin 12: gpio or the interrupt output; direction stays software's job
            if (state_ff.route.sys_mgmt_irq_en) begin
                p12_level = !sys_mgmt_irq_req ^ pin_twelve_gp_pol;
            end else begin
                p12_level = pin_twelve_gp_val ^ pin_twelve_gp_pol;
            end
            nxt_state.p12_o = p12_level;
            nxt_state.p12_oe = pin_twelve_gp_dir
                && (!state_ff.regs.drv1[gpcfg_pkg::DRV1_P12] || !p12_level);
            nxt_state.p12_in = state_ff.filt[gpcfg_pkg::SYNC_P12] ^ pin_twelve_gp_pol;

            // open-drain flags copied from the drive registers, function routing decoded from the select registers
            nxt_state.route.od_grp1 = {state_ff.regs.drv1[gpcfg_pkg::DRV1_P17],
                state_ff.regs.drv1[gpcfg_pkg::DRV1_P16],
                state_ff.regs.drv1[gpcfg_pkg::DRV1_P13],
                state_ff.regs.drv1[gpcfg_pkg::DRV1_P12],
                state_ff.regs.drv1[gpcfg_pkg::DRV1_P11]};
            nxt_state.route.od_grp2 = {state_ff.regs.drv2[gpcfg_pkg::DRV2_WAKE],
                state_ff.regs.drv2[gpcfg_pkg::DRV2_P23],
                state_ff.regs.drv2[gpcfg_pkg::DRV2_P21],
                state_ff.regs.drv2[gpcfg_pkg::DRV2_P20]};
            nxt_state.route.sys_mgmt_irq_en =
                state_ff.regs.alt1[gpcfg_pkg::FLD_MH +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.routable_irq_in_one_en =
                state_ff.regs.alt1[gpcfg_pkg::FLD_HI +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.led_drive_one_en =
                state_ff.regs.alt1[gpcfg_pkg::FLD_HI +: 2] == gpcfg_pkg::FN_ALT_B;
            nxt_state.route.pin_sixteen_gpio_en =
                state_ff.regs.alt2[gpcfg_pkg::FLD_MH +: 2] == gpcfg_pkg::FN_GPIO;
            nxt_state.route.pin_seventeen_gpio_en =
                state_ff.regs.alt2[gpcfg_pkg::FLD_HI +: 2] == gpcfg_pkg::FN_GPIO;
            nxt_state.route.infrared_rx_two_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_LO +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.routable_irq_in_three_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_LO +: 2] == gpcfg_pkg::FN_ALT_B;
            nxt_state.route.infrared_tx_two_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_ML +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.watchdog_out_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_ML +: 2] == gpcfg_pkg::FN_ALT_B;
            // what the fast-infrared output means is chosen elsewhere; this only routes it
            nxt_state.route.fast_infrared_mode_out_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_MH +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.led_drive_two_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_HI +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.routable_irq_in_two_en =
                state_ff.regs.alt3[gpcfg_pkg::FLD_HI +: 2] == gpcfg_pkg::FN_ALT_B;
            nxt_state.route.port3_ring_ind_en =
                state_ff.regs.alt5[gpcfg_pkg::FLD_LO +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.port3_carrier_det_en =
                state_ff.regs.alt5[gpcfg_pkg::FLD_ML +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.port3_rx_line_en =
                state_ff.regs.alt5[gpcfg_pkg::FLD_MH +: 2] == gpcfg_pkg::FN_ALT_A;
            nxt_state.route.port3_tx_line_en =
                state_ff.regs.alt5[gpcfg_pkg::FLD_HI +: 2] == gpcfg_pkg::FN_ALT_A;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // rst_b is the standby-power reset; everything not listed starts at zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
            state_ff.regs.drv2 <= gpcfg_pkg::RST_DRV2;
            state_ff.regs.alt2 <= gpcfg_pkg::RST_ALT2;
            state_ff.route.od_grp2[3] <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        io_rdata = state_ff.rdata;
        grp4_pad_o = state_ff.grp4.o;
        grp4_pad_oe = state_ff.grp4.oe;
        grp4_in_val = state_ff.grp4.in_val;
        grp5_pad_o = state_ff.grp5.o;
        grp5_pad_oe = state_ff.grp5.oe;
        grp5_in_val = state_ff.grp5.in_val;
        pin_twelve_pad_o = state_ff.p12_o;
        pin_twelve_pad_oe = state_ff.p12_oe;
        pin_twelve_in_val = state_ff.p12_in;
        route = state_ff.route;
    end

endmodule

// ==== gpcfg_pkg.sv ====
// constants and carrier types for the pin configuration register bank
package gpcfg_pkg;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [7:0] IDX_DIR4 = 8'h37;
    localparam logic [7:0] IDX_POL4 = 8'h38;
    localparam logic [7:0] IDX_DRV1 = 8'h39;
    localparam logic [7:0] IDX_TEST5 = 8'h3A;
    localparam logic [7:0] IDX_RSVD_LO = 8'h3B;
    localparam logic [7:0] IDX_RSVD_HI = 8'h3F;
    localparam logic [7:0] IDX_DRV2 = 8'h40;
    localparam logic [7:0] IDX_DRV5 = 8'h41;
    localparam logic [7:0] IDX_DIR5 = 8'h42;
    localparam logic [7:0] IDX_POL5 = 8'h43;
    localparam logic [7:0] IDX_ALT1 = 8'h44;
    localparam logic [7:0] IDX_ALT2 = 8'h45;
    localparam logic [7:0] IDX_ALT3 = 8'h46;
    localparam logic [7:0] IDX_RSVD47 = 8'h47;
    localparam logic [7:0] IDX_ALT5 = 8'h48;

    // ****************************************
    // writable bit masks and reset values
    // ****************************************
    localparam logic [7:0] MASK_DRV1 = 8'hCE;
    localparam logic [7:0] MASK_DRV2 = 8'h8B;
    localparam logic [7:0] MASK_ALT1 = 8'hFC;
    localparam logic [7:0] MASK_ALT2 = 8'hF0;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DRV2 = 8'h80;
    localparam logic [7:0] RST_ALT2 = 8'h50;
    localparam logic [3:0] RST_ALT2_HI = 4'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int DRV1_P11 = 1;
    localparam int DRV1_P12 = 2;
    localparam int DRV1_P13 = 3;
    localparam int DRV1_P16 = 6;
    localparam int DRV1_P17 = 7;
    localparam int DRV2_P20 = 0;
    localparam int DRV2_P21 = 1;
    localparam int DRV2_P23 = 3;
    localparam int DRV2_WAKE = 7;
    localparam int FLD_LO = 0;
    localparam int FLD_ML = 2;
    localparam int FLD_MH = 4;
    localparam int FLD_HI = 6;

    // ****************************************
    // function select codes
    // ****************************************
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_ALT_A = 2'h1;
    localparam logic [1:0] FN_ALT_B = 2'h2;

    // ****************************************
    // port access and pad synchroniser layout
    // ****************************************
    localparam logic PORT_INDEX = 1'b0;
    localparam logic PORT_DATA = 1'b1;
    localparam int SYNC_W = 17;
    localparam int SYNC_P12 = 16;

    typedef struct packed {
        logic [7:0] dir4;
        logic [7:0] pol4;
        logic [7:0] drv1;
        logic [7:0] test5;
        logic [7:0] drv2;
        logic [7:0] drv5;
        logic [7:0] dir5;
        logic [7:0] pol5;
        logic [7:0] alt1;
        logic [7:0] alt2;
        logic [7:0] alt3;
        logic [7:0] alt5;
    } gpcfg_regs_type;

    typedef struct packed {
        logic [4:0] od_grp1;
        logic [3:0] od_grp2;
        logic sys_mgmt_irq_en;
        logic routable_irq_in_one_en;
        logic led_drive_one_en;
        logic infrared_rx_two_en;
        logic routable_irq_in_three_en;
        logic infrared_tx_two_en;
        logic watchdog_out_en;
        logic fast_infrared_mode_out_en;
        logic led_drive_two_en;
        logic routable_irq_in_two_en;
        logic port3_ring_ind_en;
        logic port3_carrier_det_en;
        logic port3_rx_line_en;
        logic port3_tx_line_en;
        logic pin_sixteen_gpio_en;
        logic pin_seventeen_gpio_en;
    } gpcfg_route_type;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] in_val;
    } gpcfg_pads_type;

    typedef struct packed {
        gpcfg_regs_type regs;
        logic [7:0] index;
        logic [7:0] rdata;
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [SYNC_W-1:0] sync3;
        logic [SYNC_W-1:0] filt;
        gpcfg_pads_type grp4;
        gpcfg_pads_type grp5;
        logic p12_o;
        logic p12_oe;
        logic p12_in;
        gpcfg_route_type route;
    } gpcfg_state_type;

endpackage

// ==== gpcfg_bank_properties.sv ====
// concurrent checks on the ports of the pin configuration bank
`timescale 1ns/100ps
module gpcfg_bank_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic main_por_req,
    input wire logic hard_rst_req,
    input wire logic cfg_mode,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_port_sel,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] grp4_out_val,
    input wire logic [7:0] grp4_pad_i,
    input wire logic [7:0] grp4_pad_o,
    input wire logic [7:0] grp4_pad_oe,
    input wire logic [7:0] grp4_in_val,
    input wire logic sys_mgmt_irq_req,
    input wire logic pin_twelve_gp_pol,
    input wire logic pin_twelve_pad_o,
    input wire gpcfg_pkg::gpcfg_route_type route
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic acc;
    // a main reset in the same cycle clears the index, so such accesses are left out
    assign acc = clk_en && cfg_mode && !main_por_req;
    // ****
    // sequences
    // ****
    sequence rsvd_idx_s;
        acc && io_wr && !io_port_sel && (io_wdata inside {[8'h3B:8'h3F], 8'h47});
    endsequence
    sequence idx_set_s;
        acc && io_wr && !io_port_sel;
    endsequence
    sequence data_rd_s;
        acc && io_rd && io_port_sel && !io_wr;
    endsequence
    // ****
    // assertions
    // ****
    rdata_hold_a: assert property (!(clk_en && cfg_mode && io_rd) |=> $stable(io_rdata))
        else $error("read data moved without a read");
    // the host leaves one idle cycle between loading the index and the following read
    rsvd_read_a: assert property (rsvd_idx_s ##1 !io_wr ##1 data_rd_s |=> io_rdata == 8'h00)
        else $error("reserved index read not zero");
    index_back_a: assert property (idx_set_s ##1 (!io_wr && !main_por_req) ##1 (acc && io_rd && !io_port_sel)
        |=> io_rdata == $past(io_wdata, 3))
        else $error("index port read wrong");
    pol_match_a: assert property ((clk_en && !io_wr && $stable(grp4_pad_i) && $stable(grp4_out_val))[*7]
        |-> (grp4_in_val ^ grp4_pad_i) == (grp4_pad_o ^ grp4_out_val))
        else $error("input and output polarity disagree");
    dir_quiet_a: assert property (!io_wr [*3] |-> $stable(grp4_pad_oe))
        else $error("direction moved without a write");
    route_cause_a: assert property ($past(clk_en) && $past(clk_en, 2) && $changed(route)
        |-> $past(io_wr || main_por_req || hard_rst_req, 2))
        else $error("route moved without a cause");
    irq_low_a: assert property (route.sys_mgmt_irq_en && $past(route.sys_mgmt_irq_en) && $past(clk_en)
        && !$past(pin_twelve_gp_pol) |-> pin_twelve_pad_o == !$past(sys_mgmt_irq_req))
        else $error("interrupt output not active low");
    grp_hi_reset_a: assert property (hard_rst_req && clk_en ##1 clk_en
        |=> !route.pin_sixteen_gpio_en && !route.pin_seventeen_gpio_en)
        else $error("pin 16 or 17 still plain after hard reset");
endmodule

// ==== test_gpio_pin_config_bank.sv ====
// self-checking bench for the pin configuration bank
`timescale 1ns/100ps
module test_gpio_pin_config_bank;
    logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, main_por_req = 1'b0, hard_rst_req = 1'b0, cfg_mode = 1'b1;
    logic io_wr = 1'b0, io_rd = 1'b0, io_port_sel = 1'b0, sys_mgmt_irq_req = 1'b0, pin_twelve_gp_val = 1'b0;
    logic pin_twelve_gp_dir = 1'b0, pin_twelve_gp_pol = 1'b0, pin_twelve_pad_i = 1'b0;
    logic [7:0] io_wdata = 8'h00, grp4_out_val = 8'h00, grp4_pad_i = 8'h00, grp5_out_val = 8'h00, grp5_pad_i = 8'h00;
    logic [7:0] io_rdata, grp4_pad_o, grp4_pad_oe, grp4_in_val, grp5_pad_o, grp5_pad_oe, grp5_in_val, d;
    logic pin_twelve_pad_o, pin_twelve_pad_oe, pin_twelve_in_val, e, g, z;
    logic [1:0] c;
    logic [7:0] pat [2] = '{8'hFF, 8'h5A};
    gpcfg_pkg::gpcfg_route_type route;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    gpcfg_bank DUT (.clk, .rst_b, .clk_en, .main_por_req, .hard_rst_req, .cfg_mode, .io_wr, .io_rd, .io_port_sel,
        .io_wdata, .io_rdata, .grp4_out_val, .grp4_pad_i, .grp4_pad_o, .grp4_pad_oe, .grp4_in_val, .grp5_out_val,
        .grp5_pad_i, .grp5_pad_o, .grp5_pad_oe, .grp5_in_val, .sys_mgmt_irq_req, .pin_twelve_gp_val,
        .pin_twelve_gp_dir, .pin_twelve_gp_pol, .pin_twelve_pad_i, .pin_twelve_pad_o, .pin_twelve_pad_oe,
        .pin_twelve_in_val, .route);
    always #12.5 clk = ~clk;
    // ****
    // access tasks
    // ****
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic sel, input logic [7:0] v);
        @(negedge clk);
        io_port_sel = sel;
        io_wdata = v;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    // read data is registered at the read edge, so it is settled by the next falling edge
    task automatic get(input logic sel, output logic [7:0] v);
        @(negedge clk);
        io_port_sel = sel;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        v = io_rdata;
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] v);
        put(1'b0, i);
        put(1'b1, v);
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] x);
        put(1'b0, i);
        get(1'b1, d);
        cmp({8'h00, d}, {8'h00, x});
    endtask
    function automatic logic [7:0] wmask(input logic [7:0] i);
        case (i)
            8'h39: return 8'hCE;
            8'h40: return 8'h8B;
            8'h44: return 8'hFC;
            8'h45: return 8'hF0;
            8'h37, 8'h38, 8'h41, 8'h42, 8'h43, 8'h46, 8'h48: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ****
    // tests
    // ****
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 8'h37; i <= 8'h48; i++) begin
            rchk(8'(i), i == 8'h40 ? 8'h80 : i == 8'h45 ? 8'h50 : 8'h00);
        end
        cmp({12'h000, route.od_grp2}, 16'h0008);
        $display("reset values done");
        // the test register is skipped: setting it is not allowed to software
        foreach (pat[p]) begin
            for (int i = 8'h37; i <= 8'h48; i++) begin
                if (i != 8'h3A) begin
                    wreg(8'(i), pat[p]);
                    rchk(8'(i), pat[p] & wmask(8'(i)));
                end
            end
        end
        $display("write masks done");
        put(1'b0, 8'h42);
        get(1'b0, d);
        cmp({8'h00, d}, 16'h0042);
        cfg_mode = 1'b0;
        wreg(8'h42, 8'h00);
        cfg_mode = 1'b1;
        rchk(8'h42, 8'h5A);
        $display("access gating done");
        wreg(8'h37, 8'hF0);
        wreg(8'h38, 8'h0F);
        wreg(8'h42, 8'hFF);
        wreg(8'h41, 8'h0F);
        wreg(8'h43, 8'h00);
        grp4_out_val = 8'h33;
        grp4_pad_i = 8'h55;
        grp5_out_val = 8'h55;
        grp5_pad_i = 8'hC3;
        pin_twelve_pad_i = 1'b1;
        repeat (8) @(negedge clk);
        cmp({grp4_pad_oe, grp4_pad_o}, 16'hF03C);
        cmp({grp4_in_val, grp5_in_val}, 16'h5AC3);
        cmp({grp5_pad_oe, grp5_pad_o}, 16'hFA55);
        cmp({15'h0000, pin_twelve_in_val}, 16'h0001);
        wreg(8'h44, 8'h10);
        wreg(8'h39, 8'h04);
        pin_twelve_gp_dir = 1'b1;
        sys_mgmt_irq_req = 1'b1;
        repeat (3) @(negedge clk);
        cmp({8'h00, pin_twelve_pad_oe, route.sys_mgmt_irq_en, route.od_grp1, pin_twelve_pad_o}, 16'h00C4);
        sys_mgmt_irq_req = 1'b0;
        repeat (2) @(negedge clk);
        cmp({14'h0000, pin_twelve_pad_oe, pin_twelve_pad_o}, 16'h0001);
        $display("pad behaviour done");
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            e = (c == 2'h1);
            g = (c == 2'h2);
            z = (c == 2'h0);
            wreg(8'h44, {c, c, c, c});
            wreg(8'h45, {c, c, 4'h0});
            wreg(8'h46, {c, c, c, c});
            wreg(8'h48, {c, c, c, c});
            repeat (3) @(negedge clk);
            cmp(route[15:0], {e, e, g, e, g, e, g, e, e, g, e, e, e, e, z, z});
        end
        pin_twelve_gp_val = 1'b1;
        pin_twelve_gp_pol = 1'b1;
        repeat (6) @(negedge clk);
        cmp({13'h0000, pin_twelve_pad_oe, pin_twelve_pad_o, pin_twelve_in_val}, 16'h0004);
        $display("function codes done");
        wreg(8'h45, 8'h00);
        put(1'b0, 8'h42);
        main_por_req = 1'b1;
        @(negedge clk);
        main_por_req = 1'b0;
        get(1'b0, d);
        cmp({8'h00, d}, 16'h0000);
        rchk(8'h3A, 8'h00);
        cmp({14'h0000, route[1:0]}, 16'h0000);
        wreg(8'h45, 8'h00);
        repeat (2) @(negedge clk);
        cmp({14'h0000, route[1:0]}, 16'h0003);
        hard_rst_req = 1'b1;
        @(negedge clk);
        hard_rst_req = 1'b0;
        repeat (2) @(negedge clk);
        cmp({14'h0000, route[1:0]}, 16'h0000);
        rchk(8'h45, 8'h50);
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        rchk(8'h40, 8'h80);
        rchk(8'h42, 8'h00);
        $display("resets done");
        give_verdict();
    end
endmodule
bind gpcfg_bank gpcfg_bank_properties u_props (.clk, .rst_b, .clk_en, .main_por_req, .hard_rst_req, .cfg_mode,
    .io_wr, .io_rd, .io_port_sel, .io_wdata, .io_rdata, .grp4_out_val, .grp4_pad_i, .grp4_pad_o, .grp4_pad_oe,
    .grp4_in_val, .sys_mgmt_irq_req, .pin_twelve_gp_pol, .pin_twelve_pad_o, .route);
